// ==== clock_edge_flag.sv ====
// rising-edge activity flag for one foreign clock, cleared on read
`timescale 1ns/1ps
`default_nettype none
module clock_edge_flag (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // monitored clock
   input wire logic mon_clock,
   // clear request and flag
   input wire logic clear,
   output logic flag
);
   logic s1;
   logic s2;
   logic s3;
   logic s4;
   wire logic rise;

   // s1 only feeds s2; a rise counts once s2 and s3 are both high and s4 is low
   assign rise = s2 & s3 & ~s4;

   always_ff @(posedge clk) begin
      if (reset) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         s4 <= 1'b0;
      end else begin
         s1 <= mon_clock;
         s2 <= s1;
         s3 <= s2;
         s4 <= s3;
      end
   end

   // set wins so an edge seen in the read cycle survives
   always_ff @(posedge clk) begin
      if (reset) begin
         flag <= 1'b0;
      end else if (rise) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end
endmodule : clock_edge_flag
`default_nettype wire

// ==== gcfg_map.svh ====
// register map, field positions and reset values for the global config block
`ifndef GCFG_MAP_SVH
`define GCFG_MAP_SVH

`define GCFG_ADDR_W 11
`define GCFG_QUAD_SPAN 11'h100
`define GCFG_TEST_BASE 11'h400
`define GCFG_OFS_GLOBAL 8'h00
`define GCFG_OFS_CLKMON 8'h01
`define GCFG_ADDR_REFSEL 11'h0BB
`define GCFG_GLOBAL_RESET 8'h00
`define GCFG_REFSEL_RESET 2'h0
`define GCFG_BIT_GPIO_DIR 7
`define GCFG_BIT_GPIO_VAL 6
`define GCFG_BIT_IDLE_GAP 5
`define GCFG_BIT_LOSS_SRC 4
`define GCFG_BIT_MF_FORCE 3
`define GCFG_BIT_OOF_TRUNK 2
`define GCFG_BIT_GLOB_TRUNK 1
`define GCFG_BIT_LINE_MODE 0
`define GCFG_BIT_REF_ACT 4
`define GCFG_BIT_BPTX_ACT 3
`define GCFG_BIT_CTX_ACT 2
`define GCFG_BIT_BPRX_ACT 1
`define GCFG_REF_QUAD 2'h3
`define GCFG_FIRST_QUAD 2'h0

`endif

// ==== gcfg_pkg.sv ====
// shared types for the global config block
package gcfg_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [1:0] quad_t;
endpackage : gcfg_pkg

// ==== global_config_clock_monitor.sv ====
// four-quadrant global configuration and clock activity monitor
//
// Overview of operation
// - direction bit 1 drives general-purpose pin; 0 makes it an input.
// - after reset the general-purpose pin is an input.
// - value bit sets pin when output; reads pin level when input.
// - direction, value and line mode exist only in quadrant one.
// - line mode 1 selects E1 for all quadrants, 0 selects T1.
// - E1 with multiframe force: signaling-multiframe loss forces signaling all ones.
// - loss source bit picks analog (0) or digital (1) loss.
// - in loss, reference output from common clock, else recovered clock.
// - single reference select register chooses the source quadrant.
// - T1 idle gapping withholds framing bits from the inband code detector.
// - out-of-frame trunk bit with store in use: all timeslots idle code.
// - global trunk bit substitutes per-channel trunk data and signaling.
// - activity flags set on rising edges, bits four down to one.
// - any clock monitor read clears all its activity flags except one set by an edge in the same cycle.
// - reference clock flag lives only in quadrant four monitor.
// - writable bits reset to zero and read back as written, except value bit, which reads pin level when input.
`timescale 1ns/1ps
`default_nettype none
`include "gcfg_map.svh"
module global_config_clock_monitor #(
   parameter int QUADS = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [`GCFG_ADDR_W-1:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   // general-purpose pin
   input wire logic gpio_in,
   output logic gpio_out,
   output logic gpio_oe,
   // monitored clocks
   input wire logic common_ref_clock,
   input wire logic [QUADS-1:0] bp_tx_clock,
   input wire logic [QUADS-1:0] common_tx_clock,
   input wire logic [QUADS-1:0] bp_rx_clock,
   // per-quadrant status from framers
   input wire logic [QUADS-1:0] analog_los,
   input wire logic [QUADS-1:0] digital_los,
   input wire logic [QUADS-1:0] out_of_sig_multiframe,
   input wire logic [QUADS-1:0] out_of_frame,
   input wire logic [QUADS-1:0] rx_estore_bypass,
   input wire logic [QUADS-1:0] framing_bit_slot,
   input wire logic [QUADS-1:0] rx_recovered_clk,
   // global controls
   output logic line_mode_select,
   output logic rx_reference_out,
   // per-quadrant controls
   output logic [QUADS-1:0] rx_bp_sig_all_ones,
   output logic [QUADS-1:0] idle_fill_all_slots,
   output logic [QUADS-1:0] global_trunk_cond,
   output logic [QUADS-1:0] inband_data_gap
);
   // ************************************************
   // address decode
   // ************************************************
   wire logic [1:0] quad_sel;
   wire logic [7:0] ofs;
   wire logic in_normal;
   wire logic hit_global;
   wire logic hit_clkmon;
   wire logic hit_refsel;

   assign in_normal = addr < `GCFG_TEST_BASE;
   assign quad_sel = addr[9:8];
   assign ofs = addr[7:0];
   assign hit_refsel = (addr == `GCFG_ADDR_REFSEL);
   assign hit_global = in_normal && (ofs == `GCFG_OFS_GLOBAL);
   assign hit_clkmon = in_normal && (ofs == `GCFG_OFS_CLKMON);

   // ************************************************
   // configuration storage
   // ************************************************
   gcfg_pkg::reg_byte_t global_cfg [QUADS];
   gcfg_pkg::quad_t ref_quad;
   logic [2:0] gpio_sync;

   // only quadrant one holds bits 7, 6 and 0; the rest store bits 5..1
   localparam gcfg_pkg::reg_byte_t Q0_MASK = 8'hFF;
   localparam gcfg_pkg::reg_byte_t QN_MASK = 8'h3E;

   genvar q;
   generate
      for (q = 0; q < QUADS; q++) begin : g_cfg
         wire logic wr_q;
         assign wr_q = wr_en && hit_global && (quad_sel == q[1:0]);
         always_ff @(posedge clk) begin
            if (reset) begin
               global_cfg[q] <= `GCFG_GLOBAL_RESET;
            end else if (wr_q) begin
               global_cfg[q] <= wr_data & ((q == 0) ? Q0_MASK : QN_MASK);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         ref_quad <= `GCFG_REFSEL_RESET;
      end else if (wr_en && hit_refsel) begin
         ref_quad <= wr_data[1:0];
      end
   end

   // pin level is asynchronous; three stages, change counts when 2 and 3 agree
   logic gpio_level;
   always_ff @(posedge clk) begin
      if (reset) begin
         gpio_sync <= 3'h0;
         gpio_level <= 1'b0;
      end else begin
         gpio_sync <= {gpio_sync[1:0], gpio_in};
         if (gpio_sync[1] == gpio_sync[2]) begin
            gpio_level <= gpio_sync[2];
         end
      end
   end

   // ************************************************
   // clock activity flags
   // ************************************************
   wire logic clkmon_rd;
   assign clkmon_rd = rd_en && hit_clkmon;

   logic [QUADS-1:0] bptx_act;
   logic [QUADS-1:0] ctx_act;
   logic [QUADS-1:0] bprx_act;
   logic ref_act;
   wire logic [QUADS-1:0] clr_q;

   generate
      for (q = 0; q < QUADS; q++) begin : g_mon
         assign clr_q[q] = clkmon_rd && (quad_sel == q[1:0]);
         clock_edge_flag u_bptx (
            .clk(clk),
            .reset(reset),
            .mon_clock(bp_tx_clock[q]),
            .clear(clr_q[q]),
            .flag(bptx_act[q])
         );
         clock_edge_flag u_ctx (
            .clk(clk),
            .reset(reset),
            .mon_clock(common_tx_clock[q]),
            .clear(clr_q[q]),
            .flag(ctx_act[q])
         );
         clock_edge_flag u_bprx (
            .clk(clk),
            .reset(reset),
            .mon_clock(bp_rx_clock[q]),
            .clear(clr_q[q]),
            .flag(bprx_act[q])
         );
      end
   endgenerate

   // shared reference clock, reported only through quadrant four
   clock_edge_flag u_ref (
      .clk(clk),
      .reset(reset),
      .mon_clock(common_ref_clock),
      .clear(clr_q[`GCFG_REF_QUAD]),
      .flag(ref_act)
   );

   // ************************************************
   // read data
   // ************************************************
   gcfg_pkg::reg_byte_t cfg_view;
   gcfg_pkg::reg_byte_t mon_view;
   wire logic [7:0] next_rd_data;

   always_comb begin
      cfg_view = global_cfg[quad_sel];
      if (quad_sel == `GCFG_FIRST_QUAD && !global_cfg[0][`GCFG_BIT_GPIO_DIR]) begin
         cfg_view[`GCFG_BIT_GPIO_VAL] = gpio_level;
      end
      mon_view = 8'h00;
      mon_view[`GCFG_BIT_BPTX_ACT] = bptx_act[quad_sel];
      mon_view[`GCFG_BIT_CTX_ACT] = ctx_act[quad_sel];
      mon_view[`GCFG_BIT_BPRX_ACT] = bprx_act[quad_sel];
      if (quad_sel == `GCFG_REF_QUAD) begin
         mon_view[`GCFG_BIT_REF_ACT] = ref_act;
      end
   end

   assign next_rd_data = hit_refsel ? {6'h00, ref_quad} :
                         hit_global ? cfg_view :
                         hit_clkmon ? mon_view : 8'h00;

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= next_rd_data;
      end
   end

   // ************************************************
   // control outputs
   // ************************************************
   wire logic e1_mode;
   assign e1_mode = global_cfg[0][`GCFG_BIT_LINE_MODE];

   wire logic [QUADS-1:0] next_sig_ones;
   wire logic [QUADS-1:0] next_idle_fill;
   wire logic [QUADS-1:0] next_glob_trunk;
   wire logic [QUADS-1:0] next_gap;
   wire logic [QUADS-1:0] quad_los;

   generate
      for (q = 0; q < QUADS; q++) begin : g_ctl
         assign next_sig_ones[q] = e1_mode && global_cfg[q][`GCFG_BIT_MF_FORCE]
                                   && out_of_sig_multiframe[q];
         assign next_idle_fill[q] = global_cfg[q][`GCFG_BIT_OOF_TRUNK]
                                    && !rx_estore_bypass[q] && out_of_frame[q];
         assign next_glob_trunk[q] = global_cfg[q][`GCFG_BIT_GLOB_TRUNK];
         assign next_gap[q] = !e1_mode && global_cfg[q][`GCFG_BIT_IDLE_GAP]
                              && framing_bit_slot[q];
         assign quad_los[q] = global_cfg[q][`GCFG_BIT_LOSS_SRC] ?
                              digital_los[q] : analog_los[q];
      end
   endgenerate

   // reference output is a registered mux; its rate is bounded by clk
   wire logic next_ref_out;
   assign next_ref_out = quad_los[ref_quad] ? common_ref_clock
                                            : rx_recovered_clk[ref_quad];

   always_ff @(posedge clk) begin
      if (reset) begin
         gpio_oe <= 1'b0;
      end else begin
         gpio_oe <= global_cfg[0][`GCFG_BIT_GPIO_DIR];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         gpio_out <= 1'b0;
      end else begin
         gpio_out <= global_cfg[0][`GCFG_BIT_GPIO_VAL];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         line_mode_select <= 1'b0;
      end else begin
         line_mode_select <= e1_mode;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_reference_out <= 1'b0;
      end else begin
         rx_reference_out <= next_ref_out;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_bp_sig_all_ones <= '0;
      end else begin
         rx_bp_sig_all_ones <= next_sig_ones;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         idle_fill_all_slots <= '0;
      end else begin
         idle_fill_all_slots <= next_idle_fill;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         global_trunk_cond <= '0;
      end else begin
         global_trunk_cond <= next_glob_trunk;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         inband_data_gap <= '0;
      end else begin
         inband_data_gap <= next_gap;
      end
   end
endmodule : global_config_clock_monitor
`default_nettype wire

// ==== global_config_clock_monitor_assertions.sv ====
// port-level assertions for the global config clock monitor
`timescale 1ns/1ps
`default_nettype none
`include "gcfg_map.svh"
module gcfg_checker #(parameter int QUADS = 4) (
   // clock, reset and register port
   input wire logic clk, reset, wr_en, rd_en,
   input wire logic [`GCFG_ADDR_W-1:0] addr,
   input wire logic [7:0] wr_data, rd_data,
   // pin and controls
   input wire logic gpio_out, gpio_oe, line_mode_select,
   input wire logic [QUADS-1:0] out_of_sig_multiframe, out_of_frame, rx_estore_bypass,
   input wire logic [QUADS-1:0] framing_bit_slot, rx_bp_sig_all_ones, idle_fill_all_slots,
   input wire logic [QUADS-1:0] inband_data_gap
);
   // ****
   // properties
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic wr_q0 = wr_en && addr == 11'h000;
   pin_input_reset_a: assert property ($fell(reset) |-> !gpio_oe && !gpio_out)
      else $error("pin not input after reset");
   pin_drive_a: assert property (wr_q0 && wr_data[7] |-> ##[1:2] gpio_oe)
      else $error("pin not driven");
   pin_value_a: assert property (wr_q0 && wr_data[7:6] == 2'h3 |-> ##[1:2] gpio_out)
      else $error("pin level wrong");
   line_mode_a: assert property (wr_q0 && wr_data[0] |-> ##[1:2] line_mode_select)
      else $error("line mode not set");
   sig_force_a: assert property ((rx_bp_sig_all_ones & ~$past(out_of_sig_multiframe)) == '0)
      else $error("signaling forced without cause");
   idle_fill_a: assert property
      ((idle_fill_all_slots & ($past(rx_estore_bypass) | ~$past(out_of_frame))) == '0)
      else $error("idle fill without cause");
   gap_t1_a: assert property (inband_data_gap != '0 |-> !line_mode_select &&
      (inband_data_gap & ~$past(framing_bit_slot)) == '0) else $error("gap outside T1 slot");
   reserved_read_a: assert property (rd_en && addr >= 11'h400 |=> rd_data == 8'h00)
      else $error("reserved read not zero");
endmodule : gcfg_checker
bind global_config_clock_monitor gcfg_checker #(.QUADS(QUADS)) chk (.clk(clk), .reset(reset),
   .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
   .gpio_out(gpio_out), .gpio_oe(gpio_oe), .line_mode_select(line_mode_select),
   .out_of_sig_multiframe(out_of_sig_multiframe), .out_of_frame(out_of_frame),
   .rx_estore_bypass(rx_estore_bypass), .framing_bit_slot(framing_bit_slot),
   .rx_bp_sig_all_ones(rx_bp_sig_all_ones), .idle_fill_all_slots(idle_fill_all_slots),
   .inband_data_gap(inband_data_gap));
`default_nettype wire

// ==== global_config_clock_monitor_test.sv ====
// self-checking bench for the global config clock monitor
`timescale 1ns/1ps
`default_nettype none
module global_config_clock_monitor_test;
   logic clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, gpio_in = 1'b0, ref_clk = 1'b0;
   logic [10:0] addr = 11'h000;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_data;
   logic gpio_out, gpio_oe, mode, ref_out;
   logic [3:0] btx = 4'h0, ctx = 4'h0, brx = 4'h0, alos = 4'h0, dlos = 4'h0, mf_loss = 4'h0;
   logic [3:0] oof = 4'h0, byp = 4'h0, fslot = 4'h0, rclk = 4'h0, sig1, idle, gtrk, gap;
   int fail_count = 0, comparisons = 0, cycles = 0;
   global_config_clock_monitor DUT (.clk(clk), .reset(reset), .addr(addr), .wr_en(wr_en),
      .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .common_ref_clock(ref_clk), .bp_tx_clock(btx),
      .common_tx_clock(ctx), .bp_rx_clock(brx), .analog_los(alos), .digital_los(dlos),
      .out_of_sig_multiframe(mf_loss), .out_of_frame(oof), .rx_estore_bypass(byp),
      .framing_bit_slot(fslot), .rx_recovered_clk(rclk), .line_mode_select(mode),
      .rx_reference_out(ref_out), .rx_bp_sig_all_ones(sig1), .idle_fill_all_slots(idle),
      .global_trunk_cond(gtrk), .inband_data_gap(gap));
   // ****
   // clock, timeout and shared tasks
   // ****
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic idle_for(input int n);
      repeat (n) @(posedge clk);
   endtask : idle_for
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      idle_for(3);
   endtask : wr
   task automatic rd(input logic [10:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      idle_for(1);
      chk($sformatf("read %h", a), exp, rd_data);
   endtask : rd
   // ****
   // scenarios
   // ****
   task automatic t_gpio;
      rd(11'h000, 8'h00);
      chk("pin enable", 8'h00, {7'h0, gpio_oe});
      wr(11'h000, 8'hC0);
      chk("pin enable", 8'h01, {7'h0, gpio_oe});
      chk("pin out", 8'h01, {7'h0, gpio_out});
      rd(11'h000, 8'hC0);
      gpio_in <= 1'b1;
      wr(11'h000, 8'h00);
      idle_for(6);
      chk("pin enable", 8'h00, {7'h0, gpio_oe});
      rd(11'h000, 8'h40);
      gpio_in <= 1'b0;
      idle_for(6);
      rd(11'h000, 8'h00);
   endtask : t_gpio
   task automatic t_quads;
      wr(11'h100, 8'hFF);
      rd(11'h100, 8'h3E);
      chk("quad trunk", 8'h02, {4'h0, gtrk});
      chk("line mode", 8'h00, {7'h0, mode});
      rd(11'h000, 8'h00);
      wr(11'h100, 8'h00);
      wr(11'h400, 8'hFF);
      rd(11'h400, 8'h00);
   endtask : t_quads
   task automatic t_cond;
      mf_loss <= 4'h1;
      oof <= 4'h1;
      fslot <= 4'h1;
      wr(11'h000, 8'h0F);
      chk("line mode", 8'h01, {7'h0, mode});
      chk("sig ones", 8'h01, {4'h0, sig1});
      chk("idle fill", 8'h01, {4'h0, idle});
      chk("trunk", 8'h01, {4'h0, gtrk});
      chk("gap", 8'h00, {4'h0, gap});
      byp <= 4'h1;
      wr(11'h000, 8'h2C);
      chk("idle fill", 8'h00, {4'h0, idle});
      chk("sig ones", 8'h00, {4'h0, sig1});
      chk("gap", 8'h01, {4'h0, gap});
      chk("trunk", 8'h00, {4'h0, gtrk});
      {mf_loss, oof, fslot, byp} <= 16'h0000;
      wr(11'h000, 8'h00);
   endtask : t_cond
   task automatic t_ref;
      rclk <= 4'h1;
      idle_for(4);
      chk("ref out", 8'h01, {7'h0, ref_out});
      alos <= 4'h1;
      idle_for(4);
      chk("ref out", 8'h00, {7'h0, ref_out});
      ref_clk <= 1'b1;
      idle_for(4);
      chk("ref out", 8'h01, {7'h0, ref_out});
      ref_clk <= 1'b0;
      wr(11'h000, 8'h10);
      chk("ref out", 8'h01, {7'h0, ref_out});
      dlos <= 4'h1;
      rclk <= 4'h4;
      idle_for(4);
      chk("ref out", 8'h00, {7'h0, ref_out});
      wr(11'h0BB, 8'h02);
      rd(11'h0BB, 8'h02);
      chk("ref out", 8'h01, {7'h0, ref_out});
   endtask : t_ref
   task automatic t_clkmon;
      {btx, ctx, brx, ref_clk} <= 13'h1FFF;
      idle_for(2);
      {btx, ctx, brx, ref_clk} <= 13'h0000;
      idle_for(6);
      rd(11'h001, 8'h0E);
      rd(11'h001, 8'h00);
      rd(11'h201, 8'h0E);
      rd(11'h301, 8'h1E);
      rd(11'h301, 8'h00);
      brx <= 4'h4;
      idle_for(2);
      brx <= 4'h0;
      idle_for(6);
      rd(11'h201, 8'h02);
      // edge lands in the very cycle the read clears; it must survive
      brx <= 4'h1;
      idle_for(2);
      rd(11'h001, 8'h00);
      brx <= 4'h0;
      rd(11'h001, 8'h02);
      rd(11'h001, 8'h00);
   endtask : t_clkmon
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_gpio();
      t_quads();
      t_cond();
      t_ref();
      t_clkmon();
      report_and_stop();
   end
endmodule : global_config_clock_monitor_test
`default_nettype wire
